// ### rtl/cns16_lane.sv
// one lane of shift, subtract, round, saturate
`default_nettype none
module cns16_lane (
    input wire logic [15:0] narrowIn,
    input wire logic [31:0] wideIn,
    input wire logic [4:0] leftShiftAmount,
    input wire logic [4:0] rightShiftAmount,
    input wire logic roundEnable,
    input wire logic saturateEnable,
    output logic [15:0] laneOut,
    output logic laneOverflow
);
    logic signed [31:0] extended;
    logic signed [31:0] diff;
    logic signed [32:0] shifted;
    logic signed [32:0] halfBit;
    logic signed [32:0] rounded;
    logic fits;

    always_comb
    begin
        extended = 32'(signed'(narrowIn)) <<< leftShiftAmount;
        diff = extended - signed'(wideIn);
        // one guard bit keeps rounding of the largest value from wrapping
        shifted = 33'(signed'(diff)) >>> rightShiftAmount;
        halfBit = '0;
        if (roundEnable && rightShiftAmount != 5'h00)
        begin
            halfBit = 33'(diff[rightShiftAmount - 5'h01]);
        end
        rounded = shifted + halfBit;
        fits = (rounded[32:15] == {18{1'b0}}) || (rounded[32:15] == {18{1'b1}});
        laneOverflow = !fits;
        if (saturateEnable && !fits)
        begin
            laneOut = rounded[32] ? cns16_pkg::SAT_MIN : cns16_pkg::SAT_MAX;
        end
        else
        begin
            laneOut = rounded[15:0];
        end
    end
endmodule
`default_nettype wire

// ### rtl/cns16_pkg.sv
// shared constants for the complex subtract with parallel load datapath
`default_nettype none
package cns16_pkg;
    // ========================================================================
    // instruction encoding
    localparam logic [15:0] OP_FIRST_WORD = 16'hE3FB;
    localparam logic [3:0] OP_SECOND_HI = 4'h0;
    localparam int SEC_HI_POS = 12;
    localparam int SEC_TGT_POS = 8;
    localparam int MEM_FIELD_W = 8;
    // ========================================================================
    // register file
    localparam int NUM_VREGS = 9;
    localparam logic [3:0] IDX_IMAG_WIDE = 4'h2;
    localparam logic [3:0] IDX_REAL_WIDE = 4'h3;
    localparam logic [3:0] IDX_PACKED_OPERAND = 4'h4;
    localparam logic [3:0] IDX_PACKED_RESULT = 4'h6;
    localparam logic [3:0] IDX_NINTH = 4'h8;
    localparam logic [31:0] VREG_RESET = 32'h0000_0000;
    // ========================================================================
    // status word field width, shift reset value and saturation limits
    localparam int SHIFT_W = 5;
    localparam logic [15:0] SAT_MAX = 16'h7FFF;
    localparam logic [15:0] SAT_MIN = 16'h8000;
    localparam logic [4:0] SHIFT_RESET = 5'h00;
    // ========================================================================
    // interrupt status bits
    localparam int EV_REAL_OVF = 0;
    localparam int EV_IMAG_OVF = 1;
    localparam int EV_BAD_TARGET = 2;
    localparam int EV_W = 3;
endpackage
`default_nettype wire

// ### rtl/cns16_subload.sv
// complex 16-32 subtract with parallel register load, AXI4-Lite control
`default_nettype none
module cns16_subload (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic instValid,
    input wire logic [15:0] instFirstWord,
    input wire logic [15:0] instSecondWord,
    input wire logic [31:0] memoryOperandWord,
    input wire logic [3:0] regReadIdx,
    output logic [31:0] regReadData,
    output logic instDone,
    output logic instIllegal,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    // ========================================================================
    // register map
    localparam logic [7:0] ADDR_STATUS_WORD = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
    localparam logic [7:0] ADDR_VREG_BASE = 8'h40;
    // status word bits
    localparam int SW_REAL_OVF = 0;
    localparam int SW_IMAG_OVF = 1;
    localparam int SW_ROUND = 2;
    localparam int SW_SAT = 3;
    localparam int SW_PACK = 4;
    localparam int SW_SHR_LSB = 8;
    localparam int SW_SHL_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [cns16_pkg::NUM_VREGS-1:0][31:0] vreg;
        logic realOverflowFlag;
        logic imagOverflowFlag;
        logic roundEnable;
        logic saturateEnable;
        logic complexPackOrder;
        logic [4:0] rightShiftAmount;
        logic [4:0] leftShiftAmount;
        logic [cns16_pkg::EV_W-1:0] irqStatus;
        logic [cns16_pkg::EV_W-1:0] irqMask;
        logic done;
        logic illegal;
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } cns16_state_t;

    cns16_state_t st_r;
    cns16_state_t st_nxt;

    logic [15:0] upperIn;
    logic [15:0] lowerIn;
    logic [15:0] realPart;
    logic [15:0] imagPart;
    logic [15:0] realOut;
    logic [15:0] imagOut;
    logic realOvf;
    logic imagOvf;
    logic isOp;
    logic [3:0] target;
    logic badTarget;
    logic [31:0] statusWord;

    // ========================================================================
    // operand unpacking
    always_comb
    begin
        upperIn = st_r.vreg[cns16_pkg::IDX_PACKED_OPERAND][31:16];
        lowerIn = st_r.vreg[cns16_pkg::IDX_PACKED_OPERAND][15:0];
        realPart = st_r.complexPackOrder ? lowerIn : upperIn;
        imagPart = st_r.complexPackOrder ? upperIn : lowerIn;
        isOp = instValid && instFirstWord == cns16_pkg::OP_FIRST_WORD
            && instSecondWord[15:cns16_pkg::SEC_HI_POS] == cns16_pkg::OP_SECOND_HI;
        target = instSecondWord[cns16_pkg::SEC_TGT_POS +: 4];
        // the issuer must avoid these; hardware drops the load and flags it
        badTarget = target == cns16_pkg::IDX_PACKED_RESULT
            || target >= cns16_pkg::IDX_NINTH;
    end

    cns16_lane realLane (
        .narrowIn(realPart),
        .wideIn(st_r.vreg[cns16_pkg::IDX_REAL_WIDE]),
        .leftShiftAmount(st_r.leftShiftAmount),
        .rightShiftAmount(st_r.rightShiftAmount),
        .roundEnable(st_r.roundEnable),
        .saturateEnable(st_r.saturateEnable),
        .laneOut(realOut),
        .laneOverflow(realOvf)
    );

    cns16_lane imagLane (
        .narrowIn(imagPart),
        .wideIn(st_r.vreg[cns16_pkg::IDX_IMAG_WIDE]),
        .leftShiftAmount(st_r.leftShiftAmount),
        .rightShiftAmount(st_r.rightShiftAmount),
        .roundEnable(st_r.roundEnable),
        .saturateEnable(st_r.saturateEnable),
        .laneOut(imagOut),
        .laneOverflow(imagOvf)
    );

    always_comb
    begin
        statusWord = '0;
        statusWord[SW_REAL_OVF] = st_r.realOverflowFlag;
        statusWord[SW_IMAG_OVF] = st_r.imagOverflowFlag;
        statusWord[SW_ROUND] = st_r.roundEnable;
        statusWord[SW_SAT] = st_r.saturateEnable;
        statusWord[SW_PACK] = st_r.complexPackOrder;
        statusWord[SW_SHR_LSB +: cns16_pkg::SHIFT_W] = st_r.rightShiftAmount;
        statusWord[SW_SHL_LSB +: cns16_pkg::SHIFT_W] = st_r.leftShiftAmount;
    end

    // ========================================================================
    // next state
    always_comb
    begin
        logic [31:0] merged;
        logic [cns16_pkg::EV_W-1:0] events;
        logic doWrite;
        logic [5:0] vIdx;
        merged = '0;
        events = '0;
        vIdx = '0;
        doWrite = 1'b0;
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.illegal = 1'b0;

        // bus write: address and data may arrive in either order
        if (s_axi_awvalid && !st_r.awHeld && !st_r.bValid)
        begin
            st_nxt.awHeld = 1'b1;
            st_nxt.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.wHeld && !st_r.bValid)
        begin
            st_nxt.wHeld = 1'b1;
            st_nxt.wData = s_axi_wdata;
            st_nxt.wStrb = s_axi_wstrb;
        end
        if (st_r.bValid && s_axi_bready)
        begin
            st_nxt.bValid = 1'b0;
        end
        doWrite = st_r.awHeld && st_r.wHeld;
        // software writes apply before the instruction, so hardware sets win
        if (doWrite)
        begin
            st_nxt.awHeld = 1'b0;
            st_nxt.wHeld = 1'b0;
            st_nxt.bValid = 1'b1;
            st_nxt.bResp = RESP_OKAY;
            if (st_r.awAddr == ADDR_STATUS_WORD)
            begin
                merged = statusWord;
                for (int b = 0; b < 4; b++)
                begin
                    if (st_r.wStrb[b])
                    begin
                        merged[b*8 +: 8] = st_r.wData[b*8 +: 8];
                    end
                end
                st_nxt.realOverflowFlag = merged[SW_REAL_OVF];
                st_nxt.imagOverflowFlag = merged[SW_IMAG_OVF];
                st_nxt.roundEnable = merged[SW_ROUND];
                st_nxt.saturateEnable = merged[SW_SAT];
                st_nxt.complexPackOrder = merged[SW_PACK];
                st_nxt.rightShiftAmount = merged[SW_SHR_LSB +: cns16_pkg::SHIFT_W];
                st_nxt.leftShiftAmount = merged[SW_SHL_LSB +: cns16_pkg::SHIFT_W];
            end
            else if (st_r.awAddr == ADDR_IRQ_STATUS)
            begin
                if (st_r.wStrb[0])
                begin
                    st_nxt.irqStatus = st_r.irqStatus & ~st_r.wData[cns16_pkg::EV_W-1:0];
                end
            end
            else if (st_r.awAddr == ADDR_IRQ_MASK)
            begin
                if (st_r.wStrb[0])
                begin
                    st_nxt.irqMask = st_r.wData[cns16_pkg::EV_W-1:0];
                end
            end
            else if (st_r.awAddr >= ADDR_VREG_BASE
                && st_r.awAddr < ADDR_VREG_BASE + 8'(4 * cns16_pkg::NUM_VREGS)
                && st_r.awAddr[1:0] == 2'h0)
            begin
                vIdx = 6'((st_r.awAddr - ADDR_VREG_BASE) >> 2);
                for (int b = 0; b < 4; b++)
                begin
                    if (st_r.wStrb[b])
                    begin
                        st_nxt.vreg[vIdx][b*8 +: 8] = st_r.wData[b*8 +: 8];
                    end
                end
            end
            else
            begin
                st_nxt.bResp = RESP_SLVERR;
            end
        end

        // bus read
        if (st_r.rValid && s_axi_rready)
        begin
            st_nxt.rValid = 1'b0;
        end
        if (s_axi_arvalid && !st_r.rValid)
        begin
            st_nxt.rValid = 1'b1;
            st_nxt.rResp = RESP_OKAY;
            st_nxt.rData = '0;
            if (s_axi_araddr == ADDR_STATUS_WORD)
            begin
                st_nxt.rData = statusWord;
            end
            else if (s_axi_araddr == ADDR_IRQ_STATUS)
            begin
                st_nxt.rData = 32'(st_r.irqStatus);
            end
            else if (s_axi_araddr == ADDR_IRQ_MASK)
            begin
                st_nxt.rData = 32'(st_r.irqMask);
            end
            else if (s_axi_araddr >= ADDR_VREG_BASE
                && s_axi_araddr < ADDR_VREG_BASE + 8'(4 * cns16_pkg::NUM_VREGS)
                && s_axi_araddr[1:0] == 2'h0)
            begin
                st_nxt.rData = st_r.vreg[6'((s_axi_araddr - ADDR_VREG_BASE) >> 2)];
            end
            else
            begin
                st_nxt.rResp = RESP_SLVERR;
            end
        end

        // instruction execute, single cycle
        if (isOp)
        begin
            st_nxt.done = 1'b1;
            st_nxt.vreg[cns16_pkg::IDX_PACKED_RESULT] = st_r.complexPackOrder
                ? {imagOut, realOut} : {realOut, imagOut};
            if (realOvf)
            begin
                st_nxt.realOverflowFlag = 1'b1;
                events[cns16_pkg::EV_REAL_OVF] = 1'b1;
            end
            if (imagOvf)
            begin
                st_nxt.imagOverflowFlag = 1'b1;
                events[cns16_pkg::EV_IMAG_OVF] = 1'b1;
            end
            if (badTarget)
            begin
                st_nxt.illegal = 1'b1;
                events[cns16_pkg::EV_BAD_TARGET] = 1'b1;
            end
            else
            begin
                st_nxt.vreg[target] = memoryOperandWord;
            end
        end
        st_nxt.irqStatus = st_nxt.irqStatus | events;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ========================================================================
    // outputs
    always_comb
    begin
        regReadData = regReadIdx < 4'(cns16_pkg::NUM_VREGS) ? st_r.vreg[regReadIdx] : '0;
        instDone = st_r.done;
        instIllegal = st_r.illegal;
        s_axi_awready = !st_r.awHeld && !st_r.bValid;
        s_axi_wready = !st_r.wHeld && !st_r.bValid;
        s_axi_bvalid = st_r.bValid;
        s_axi_bresp = st_r.bResp;
        s_axi_arready = !st_r.rValid;
        s_axi_rvalid = st_r.rValid;
        s_axi_rdata = st_r.rData;
        s_axi_rresp = st_r.rResp;
        irq = |(st_r.irqStatus & st_r.irqMask);
    end
endmodule
`default_nettype wire

// ### sim/cns16_host_model.sv
// issuer model: instruction words and fetched memory word
`default_nettype none
module cns16_host_model (
    input wire logic sys_clk,
    output logic instValid,
    output logic [15:0] instFirstWord,
    output logic [15:0] instSecondWord,
    output logic [31:0] memoryOperandWord
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========
    // drive
    initial
    begin
        instValid = 1'b0;
        instFirstWord = 16'h0000;
        instSecondWord = 16'h0000;
        memoryOperandWord = 32'h0000_0000;
    end
    // targets 6 and 8 only when the bench asks for them on purpose
    task automatic issue(input logic [15:0] f, input logic [15:0] s, input logic [31:0] m);
        @(posedge sys_clk);
        instValid <= 1'b1;
        instFirstWord <= f;
        instSecondWord <= s;
        memoryOperandWord <= m;
    endtask
    // released words scrambled so no stale value looks valid
    task automatic idle;
        @(posedge sys_clk);
        instValid <= 1'b0;
        instFirstWord <= ~instFirstWord;
        instSecondWord <= ~instSecondWord;
        memoryOperandWord <= ~memoryOperandWord;
    endtask
endmodule
`default_nettype wire

// ### sim/cns16_subload_checker.sv
// port checker for the complex subtract datapath
`default_nettype none
module cns16_subload_checker (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic instValid,
    input wire logic [15:0] instFirstWord,
    input wire logic [15:0] instSecondWord,
    input wire logic instDone,
    input wire logic instIllegal,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========
    // decode
    logic opHit;
    logic badTgt;
    assign opHit = instValid && instFirstWord == cns16_pkg::OP_FIRST_WORD
        && instSecondWord[15:12] == cns16_pkg::OP_SECOND_HI;
    assign badTgt = instSecondWord[11:8] == cns16_pkg::IDX_PACKED_RESULT
        || instSecondWord[11:8] >= cns16_pkg::IDX_NINTH;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    // ========
    // properties
    op_done_a: assert property (opHit |=> instDone)
        else $error("op not done");
    stray_done_a: assert property (!opHit |=> !instDone)
        else $error("done without op");
    bad_target_a: assert property (opHit && badTgt |=> instIllegal)
        else $error("bad target missed");
    good_target_a: assert property (opHit && !badTgt |=> !instIllegal)
        else $error("good target flagged");
    illegal_alone_a: assert property (instIllegal |-> instDone)
        else $error("flag without op");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("response dropped");
    // address and data taken together: held one cycle, response the next
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
endmodule
bind cns16_subload cns16_subload_checker u_chk (.sys_clk, .srst, .instValid, .instFirstWord,
    .instSecondWord, .instDone, .instIllegal, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid);
`default_nettype wire

// ### sim/test_complex_sub16_parallel_load.sv
// self-checking bench for the complex subtract with parallel load
`default_nettype none
module test_complex_sub16_parallel_load;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic instValid, instDone, instIllegal, irq;
    logic [15:0] instFirstWord, instSecondWord;
    logic [31:0] memoryOperandWord, regReadData, s_axi_rdata;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] regReadIdx = 4'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] mReg [9];
    logic [31:0] mStat;
    logic [2:0] mIrq, mMask;
    int num_errors = 0;
    int comparisons = 0;
    always #10 sys_clk = ~sys_clk;
    cns16_subload DUT (.sys_clk, .srst, .instValid, .instFirstWord, .instSecondWord,
        .memoryOperandWord, .regReadIdx, .regReadData, .instDone, .instIllegal, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
    cns16_host_model host (.sys_clk, .instValid, .instFirstWord, .instSecondWord,
        .memoryOperandWord);
    // ========
    // checking
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t response got %h expected %h", $time, got, exp);
        end
    endtask
    // ========
    // bus master; bready and rready stand from the request to the answer
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
        input logic [3:0] s = 4'hF);
        logic aw, w, b;
        b = 1'b0;
        r = 2'h3;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50 && !b; n++)
        begin
            @(negedge sys_clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge sys_clk);
            if (aw)
                s_axi_awvalid <= 1'b0;
            if (w)
                s_axi_wvalid <= 1'b0;
            if (b)
                s_axi_bready <= 1'b0;
        end
        if (!b)
        begin
            num_errors++;
            $display("[ERR] %0t write timed out", $time);
            report_and_stop;
        end
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, g;
        g = 1'b0;
        d = 32'h0000_0000;
        r = 2'h3;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50 && !g; n++)
        begin
            @(negedge sys_clk);
            ar = s_axi_arvalid && s_axi_arready;
            g = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge sys_clk);
            if (ar)
                s_axi_arvalid <= 1'b0;
            if (g)
                s_axi_rready <= 1'b0;
        end
        if (!g)
        begin
            num_errors++;
            $display("[ERR] %0t read timed out", $time);
            report_and_stop;
        end
    endtask
    // ========
    // reference model
    function automatic logic [16:0] lane(input logic [15:0] n, input logic [31:0] w,
        input logic [31:0] st);
        logic signed [31:0] d;
        longint q;
        d = ($signed({{16{n[15]}}, n}) <<< st[20:16]) - $signed(w);
        q = longint'(d) >>> st[12:8];
        if (st[2] && st[12:8] != 5'h00)
            q = q + d[st[12:8] - 5'h01];
        if (q > 32767 || q < -32768)
            return {1'b1, st[3] ? (q > 0 ? 16'h7FFF : 16'h8000) : q[15:0]};
        return {1'b0, q[15:0]};
    endfunction
    task automatic op(input logic [3:0] t, input logic [31:0] m);
        logic [16:0] re, im;
        logic p;
        host.issue(cns16_pkg::OP_FIRST_WORD, {4'h0, t, 8'($urandom)}, m);
        p = mStat[4];
        re = lane(p ? mReg[4][15:0] : mReg[4][31:16], mReg[3], mStat);
        im = lane(p ? mReg[4][31:16] : mReg[4][15:0], mReg[2], mStat);
        mStat[1:0] = mStat[1:0] | {im[16], re[16]};
        mIrq = mIrq | {1'b0, im[16], re[16]};
        mReg[6] = p ? {im[15:0], re[15:0]} : {re[15:0], im[15:0]};
        if (t == 4'h6 || t >= 4'h8)
            mIrq[2] = 1'b1;
        else
            mReg[t] = m;
    endtask
    task automatic setup(input logic [31:0] st, input logic [31:0] x, input logic [31:0] yr,
        input logic [31:0] yi);
        logic [1:0] r;
        axw(8'h00, st, r);
        axw(8'h50, x, r);
        axw(8'h4C, yr, r);
        axw(8'h48, yi, r);
        chk_resp(r, 2'h0);
        mStat = st;
        mReg[4] = x;
        mReg[3] = yr;
        mReg[2] = yi;
    endtask
    task automatic fin(input logic bad);
        host.idle;
        #1;
        chk_bit(instDone, 1'b1);
        chk_bit(instIllegal, bad);
    endtask
    task automatic regs;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 9; i++)
        begin
            @(posedge sys_clk);
            regReadIdx <= 4'(i);
            @(negedge sys_clk);
            chk(regReadData, mReg[i]);
        end
        axr(8'h00, d, r);
        chk(d, mStat);
        chk_resp(r, 2'h0);
        axr(8'h04, d, r);
        chk(d, mIrq);
        chk_bit(irq, |(mIrq & mMask));
    endtask
    // ========
    // main sequence
    initial
    begin
        logic [31:0] d, y;
        logic [1:0] r;
        void'($urandom(32'hD540A4FB));
        mReg = '{default: 32'h0000_0000};
        mIrq = 3'h0;
        mMask = 3'h0;
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        setup(32'h0002_0104, 32'h0004_0006, 32'hFFFF_FFF3, 32'h0000_0016);
        op(4'h1, $urandom);
        fin(1'b0);
        axr(8'h58, d, r);
        chk(d, 32'h000F_0001);
        for (int k = 0; k < 60; k++)
        begin
            y = $urandom;
            setup($urandom & (k[0] ? 32'h001F_1F1C : 32'h0003_031C), $urandom,
                k[0] ? $urandom : 32'($signed(y[11:0])), $urandom);
            op(4'($urandom % 6), $urandom);
            op(k[1] ? 4'h7 : 4'h4, $urandom);
            fin(1'b0);
            regs;
        end
        op(4'h6, $urandom);
        op(4'h8, $urandom);
        fin(1'b1);
        regs;
        mMask = 3'h7;
        axw(8'h08, 32'h0000_0007, r);
        regs;
        mIrq = mIrq & 3'h4;
        axw(8'h04, 32'h0000_0003, r);
        regs;
        mMask = 3'h3;
        axw(8'h08, 32'h0000_0003, r);
        regs;
        mIrq = 3'h0;
        axw(8'h04, 32'h0000_0004, r);
        regs;
        host.issue(cns16_pkg::OP_FIRST_WORD ^ 16'h0100, 16'h0100, $urandom);
        host.issue(cns16_pkg::OP_FIRST_WORD, 16'h1100, $urandom);
        host.idle;
        #1;
        chk_bit(instDone, 1'b0);
        regs;
        axr(8'h3C, d, r);
        chk_resp(r, 2'h2);
        chk(d, 32'h0000_0000);
        axw(8'hFC, 32'h0000_0000, r);
        chk_resp(r, 2'h2);
        // byte strobes: only the low half of register 0 changes
        axw(8'h40, 32'hA5A5_5A5A, r, 4'h3);
        chk_resp(r, 2'h0);
        mReg[0] = {mReg[0][31:16], 16'h5A5A};
        regs;
        report_and_stop;
    end
endmodule
`default_nettype wire
